// [core/clk_ctrl_pkg.sv]
/*
  Constants for the clock source and lock controller: register map,
  protection keys, reset values, field positions and cycle counts.
  Assumes a 100 MHz system clock and a 32-bit byte-addressed register port.
*/
`default_nettype none

package clk_ctrl_pkg;

  // ***********************************************************
  // register map (byte addresses)
  // ***********************************************************
  localparam logic [31:0] STA_ADDR      = 32'hffff0400;
  localparam logic [31:0] PWR_PRE_ADDR  = 32'hffff0404;
  localparam logic [31:0] PWR_ADDR      = 32'hffff0408;
  localparam logic [31:0] PWR_POST_ADDR = 32'hffff040c;
  localparam logic [31:0] SRC_PRE_ADDR  = 32'hffff0410;
  localparam logic [31:0] SRC_ADDR      = 32'hffff0414;
  localparam logic [31:0] SRC_POST_ADDR = 32'hffff0418;
  localparam logic [31:0] HEALTH_ADDR   = 32'hffff041c;

  // ***********************************************************
  // protection keys
  // ***********************************************************
  localparam logic [31:0] SRC_PRE_KEY  = 32'h000000aa;
  localparam logic [31:0] SRC_POST_KEY = 32'h00000055;
  localparam logic [31:0] PWR_PRE_KEY  = 32'h00000001;
  localparam logic [31:0] PWR_POST_KEY = 32'h000000f4;

  // ***********************************************************
  // fields and reset values
  // ***********************************************************
  localparam logic [1:0] SRC_RESET     = 2'h0;
  localparam logic [7:0] PWR_RESET     = 8'h79;
  localparam logic [7:0] PWR_WAKE_MASK = 8'h38;  // pll, periph, core up
  localparam int         PWR_CORE_BIT  = 3;
  localparam int         STA_FLAG_BIT  = 0;
  localparam logic [1:0] SEL_LP        = 2'h0;
  localparam logic [1:0] SEL_PREC      = 2'h1;
  localparam logic [1:0] SEL_XTAL      = 2'h2;
  localparam logic [9:0] PLL_MULT      = 10'h271;  // 625

  // synchroniser lanes
  localparam int SYNC_W    = 6;
  localparam int SYNC_LP   = 0;
  localparam int SYNC_PREC = 1;
  localparam int SYNC_XTAL = 2;
  localparam int SYNC_LOCK = 3;
  localparam int SYNC_OSC  = 4;
  localparam int SYNC_WAKE = 5;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int LOCK_TIME_US = 2000;
  localparam int CLK_MHZ      = 100;
  localparam int LOCK_CYCLES  = LOCK_TIME_US * CLK_MHZ;
  localparam int LOCK_CNT_W   = 18;

  // key sequencer states, gray along idle -> armed -> held
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'h0,
    KEY_ARMED = 2'h1,
    KEY_HELD  = 2'h3
  } key_state_type;

endpackage

`default_nettype wire

// [core/ref_if.sv]
/*
  Link between the controller and its reference divider.
  Assumes oscillator levels are already synchronised to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

interface ref_if;
  logic [2:0] osc_lvl;   // lp, precision, crystal levels
  logic [1:0] sel;       // reference choice
  logic       ref_lvl;   // 32.768 khz reference to the pll
  logic [9:0] mult;      // pll multiplier

  modport ctrl (output osc_lvl, output sel, input ref_lvl, input mult);
  modport div  (input osc_lvl, input sel, output ref_lvl, output mult);
endinterface

`default_nettype wire

// [core/ref_divider.sv]
/*
  Reference divider: divides each internal oscillator by four and picks
  the pll reference. Assumes synchronised levels and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module ref_divider
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // controller side
  ref_if.div        rif
);

  logic [1:0] prev_r;
  logic [1:0] div_w;
  logic       ref_r;
  logic [9:0] mult_r;
  logic       ref_nxt;

  // ***********************************************************
  // divide by four per internal oscillator
  // ***********************************************************
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_osc
      logic [1:0] cnt_r;
      // two rising edges per half period gives a quarter frequency
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          cnt_r     <= 2'h0;
          prev_r[i] <= 1'b0;
        end
        else
        begin
          prev_r[i] <= rif.osc_lvl[i];
          if (rif.osc_lvl[i] && !prev_r[i])
            cnt_r <= cnt_r + 2'h1;
        end
      end
      assign div_w[i] = cnt_r[1];
    end
  endgenerate

  // crystal already runs at the reference rate; reserved code parks low
  assign ref_nxt = (rif.sel == clk_ctrl_pkg::SEL_LP)   ? div_w[0] :
                   (rif.sel == clk_ctrl_pkg::SEL_PREC) ? div_w[1] :
                   (rif.sel == clk_ctrl_pkg::SEL_XTAL) ? rif.osc_lvl[2] :
                   1'b0;

  // registered reference and multiplier
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ref_r  <= 1'b0;
      mult_r <= clk_ctrl_pkg::PLL_MULT;
    end
    else
    begin
      ref_r  <= ref_nxt;
      mult_r <= clk_ctrl_pkg::PLL_MULT;
    end
  end

  assign rif.ref_lvl = ref_r;
  assign rif.mult    = mult_r;

endmodule // ref_divider

`default_nettype wire

// [core/clk_ctrl.sv]
/*
  Clock source and lock controller: keyed source and power registers,
  lock status with loss-of-lock flag, flash clock select during relock.
  Assumes a single 100 MHz clock; oscillator, lock and wake pins are
  asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none

// How it works
// - source and power registers drive clock outputs
// - core runs once pll oscillates after wake
// - flash clock divided by eight until lock
// - lock overdue flagged after two milliseconds
// - low power oscillator enable always high
// - source register needs prekey, data, postkey
// - power register needs prekey, data, postkey
// - status bit two shows live crystal level
// - status bit one shows pll locked
// - bit zero set on lock loss, write-one clears
// - low two source bits pick reference
// - pll multiplies reference by 625
// - internal oscillators divided by four
module clk_ctrl
#(
  parameter int LOCK_WAIT_CYCLES = clk_ctrl_pkg::LOCK_CYCLES
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // oscillator and pll pins
  input  wire logic        lp_osc_i,
  input  wire logic        prec_osc_i,
  input  wire logic        crystal_input_pin_i,
  input  wire logic        pll_lock_i,
  input  wire logic        pll_osc_i,
  input  wire logic        wake_i,
  // clock control outputs
  output logic      [1:0]  ref_sel_o,
  output logic      [7:0]  power_control_o,
  output logic             pll_ref_o,
  output logic      [9:0]  pll_mult_o,
  output logic             flash_div8_o,
  output logic             core_run_o,
  output logic             lp_osc_en_o,
  output logic             lock_overdue_o,
  output logic             irq_o
);

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [clk_ctrl_pkg::SYNC_W-1:0] sync1_r;
  logic [clk_ctrl_pkg::SYNC_W-1:0] sync2_r;
  logic [clk_ctrl_pkg::SYNC_W-1:0] pins_w;

  assign pins_w = {wake_i, pll_osc_i, pll_lock_i, crystal_input_pin_i,
                   prec_osc_i, lp_osc_i};

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  logic lock_s;
  logic osc_s;
  logic wake_s;
  logic xtal_s;
  assign lock_s = sync2_r[clk_ctrl_pkg::SYNC_LOCK];
  assign osc_s  = sync2_r[clk_ctrl_pkg::SYNC_OSC];
  assign wake_s = sync2_r[clk_ctrl_pkg::SYNC_WAKE];
  assign xtal_s = sync2_r[clk_ctrl_pkg::SYNC_XTAL];

  // ***********************************************************
  // key sequencers, one per protected register
  // ***********************************************************
  logic       commit_w [2];
  logic [7:0] held_w   [2];

  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_key
      localparam logic [31:0] PRE_A  = (c == 0) ? clk_ctrl_pkg::SRC_PRE_ADDR
                                                : clk_ctrl_pkg::PWR_PRE_ADDR;
      localparam logic [31:0] DAT_A  = (c == 0) ? clk_ctrl_pkg::SRC_ADDR
                                                : clk_ctrl_pkg::PWR_ADDR;
      localparam logic [31:0] POST_A = (c == 0) ? clk_ctrl_pkg::SRC_POST_ADDR
                                                : clk_ctrl_pkg::PWR_POST_ADDR;
      localparam logic [31:0] PRE_K  = (c == 0) ? clk_ctrl_pkg::SRC_PRE_KEY
                                                : clk_ctrl_pkg::PWR_PRE_KEY;
      localparam logic [31:0] POST_K = (c == 0) ? clk_ctrl_pkg::SRC_POST_KEY
                                                : clk_ctrl_pkg::PWR_POST_KEY;
      clk_ctrl_pkg::key_state_type st_r;
      clk_ctrl_pkg::key_state_type st_nxt;
      logic [7:0] hold_r;
      logic       hit_pre;
      logic       hit_dat;
      logic       hit_post;

      assign hit_pre  = wr_i && (addr_i == PRE_A) && (wdata_i == PRE_K);
      assign hit_dat  = wr_i && (addr_i == DAT_A);
      assign hit_post = wr_i && (addr_i == POST_A) && (wdata_i == POST_K);

      // any other write between the steps drops the sequence
      always_comb
      begin
        st_nxt = st_r;
        unique case (st_r)
          clk_ctrl_pkg::KEY_IDLE:
            st_nxt = hit_pre ? clk_ctrl_pkg::KEY_ARMED
                             : clk_ctrl_pkg::KEY_IDLE;
          clk_ctrl_pkg::KEY_ARMED:
            if (hit_dat)
              st_nxt = clk_ctrl_pkg::KEY_HELD;
            else if (wr_i)
              st_nxt = hit_pre ? clk_ctrl_pkg::KEY_ARMED
                               : clk_ctrl_pkg::KEY_IDLE;
          clk_ctrl_pkg::KEY_HELD:
            if (wr_i)
              st_nxt = hit_pre ? clk_ctrl_pkg::KEY_ARMED
                               : clk_ctrl_pkg::KEY_IDLE;
          default:
            st_nxt = clk_ctrl_pkg::KEY_IDLE;
        endcase
      end

      // state and the value waiting for its postwrite key
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          st_r   <= clk_ctrl_pkg::KEY_IDLE;
          hold_r <= 8'h00;
        end
        else
        begin
          st_r <= st_nxt;
          if (st_r == clk_ctrl_pkg::KEY_ARMED && hit_dat)
            hold_r <= wdata_i[7:0];
        end
      end

      assign commit_w[c] = (st_r == clk_ctrl_pkg::KEY_HELD) && hit_post;
      assign held_w[c]   = hold_r;
    end
  endgenerate

  // ***********************************************************
  // source, power and lock state
  // ***********************************************************
  logic [1:0]                        src_r;
  logic [7:0]                        pwr_r;
  logic [7:0]                        pwr_nxt;
  logic                              lock_d_r;
  logic                              wake_d_r;
  logic                              flag_r;
  logic                              flag_nxt;
  logic                              lock_fell;
  logic                              wake_rise;
  logic                              sta_clr;
  logic [clk_ctrl_pkg::LOCK_CNT_W-1:0] wait_cnt_r;
  logic                              waiting_r;
  logic                              overdue_r;

  assign lock_fell = lock_d_r && !lock_s;
  assign wake_rise = wake_s && !wake_d_r;
  assign sta_clr   = wr_i && (addr_i == clk_ctrl_pkg::STA_ADDR) &&
                     wdata_i[clk_ctrl_pkg::STA_FLAG_BIT];
  // a loss of lock in the clearing cycle keeps the flag
  assign flag_nxt  = lock_fell || (flag_r && !sta_clr);
  // wake forces pll, peripherals and core back up over any commit
  assign pwr_nxt   = (commit_w[1] ? held_w[1] : pwr_r) |
                     (wake_rise ? clk_ctrl_pkg::PWR_WAKE_MASK : 8'h00);

  // source register only changes on a completed sequence; power register also on a wake rise
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      src_r <= clk_ctrl_pkg::SRC_RESET;
      pwr_r <= clk_ctrl_pkg::PWR_RESET;
    end
    else
    begin
      if (commit_w[0])
        src_r <= held_w[0][1:0];
      pwr_r <= pwr_nxt;
    end
  end

  // lock history and loss flag
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lock_d_r <= 1'b0;
      wake_d_r <= 1'b0;
      flag_r   <= 1'b0;
    end
    else
    begin
      lock_d_r <= lock_s;
      wake_d_r <= wake_s;
      flag_r   <= flag_nxt;
    end
  end

  // lock watchdog: the relock after wake must finish within its window
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wait_cnt_r <= '0;
      waiting_r  <= 1'b0;
      overdue_r  <= 1'b0;
    end
    else if (wake_rise)
    begin
      wait_cnt_r <= '0;
      waiting_r  <= 1'b1;
      overdue_r  <= 1'b0;
    end
    else if (waiting_r)
    begin
      if (lock_s)
        waiting_r <= 1'b0;
      else if (wait_cnt_r ==
               clk_ctrl_pkg::LOCK_CNT_W'(LOCK_WAIT_CYCLES - 1))
      begin
        waiting_r <= 1'b0;
        overdue_r <= 1'b1;
      end
      else
        wait_cnt_r <= wait_cnt_r + 1'b1;
    end
  end

  // ***********************************************************
  // reference divider
  // ***********************************************************
  ref_if rif ();
  assign rif.osc_lvl = sync2_r[clk_ctrl_pkg::SYNC_XTAL:clk_ctrl_pkg::SYNC_LP];
  assign rif.sel     = src_r;

  ref_divider u_div
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .rif       (rif.div)
  );

  // ***********************************************************
  // read path
  // ***********************************************************
  logic [2:0]  sta_w;
  logic [31:0] rd_mux;
  logic        flash_div8_r;
  logic        core_run_r;
  logic        lp_en_r;
  logic        pll_ref_r;
  logic [31:0] rdata_r;

  assign sta_w  = {xtal_s, lock_s, flag_r};
  // write-only keys and unmapped addresses read as zero
  assign rd_mux =
    (addr_i == clk_ctrl_pkg::STA_ADDR)    ? {29'h0, sta_w} :
    (addr_i == clk_ctrl_pkg::SRC_ADDR)    ? {30'h0, src_r} :
    (addr_i == clk_ctrl_pkg::PWR_ADDR)    ? {24'h0, pwr_r} :
    (addr_i == clk_ctrl_pkg::HEALTH_ADDR) ? {30'h0, core_run_r, overdue_r} :
    32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rdata_r <= 32'h0;
    else
      rdata_r <= rd_i ? rd_mux : 32'h0;
  end

  // clock steering outputs
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      flash_div8_r <= 1'b1;
      core_run_r   <= 1'b0;
      lp_en_r      <= 1'b1;
      pll_ref_r    <= 1'b0;
    end
    else
    begin
      flash_div8_r <= !lock_s;
      core_run_r   <= pwr_r[clk_ctrl_pkg::PWR_CORE_BIT] && osc_s;
      lp_en_r      <= 1'b1;
      pll_ref_r    <= rif.ref_lvl;
    end
  end

  assign rdata_o         = rdata_r;
  assign ref_sel_o       = src_r;
  assign power_control_o = pwr_r;
  assign pll_ref_o       = pll_ref_r;
  assign pll_mult_o      = rif.mult;
  assign flash_div8_o    = flash_div8_r;
  assign core_run_o      = core_run_r;
  assign lp_osc_en_o     = lp_en_r;
  assign lock_overdue_o  = overdue_r;
  assign irq_o           = flag_r;

  // ***********************************************************
  // assertions
  // ***********************************************************
  logic [1:0] wd_lo;
  logic [7:0] wd_byte;
  assign wd_lo   = wdata_i[1:0];
  assign wd_byte = wdata_i[7:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_src_pre;
    wr_i && addr_i == clk_ctrl_pkg::SRC_PRE_ADDR &&
    wdata_i == clk_ctrl_pkg::SRC_PRE_KEY;
  endsequence
  sequence s_src_post;
    wr_i && addr_i == clk_ctrl_pkg::SRC_POST_ADDR &&
    wdata_i == clk_ctrl_pkg::SRC_POST_KEY;
  endsequence
  sequence s_pwr_pre;
    wr_i && addr_i == clk_ctrl_pkg::PWR_PRE_ADDR &&
    wdata_i == clk_ctrl_pkg::PWR_PRE_KEY;
  endsequence
  sequence s_pwr_post;
    wr_i && addr_i == clk_ctrl_pkg::PWR_POST_ADDR &&
    wdata_i == clk_ctrl_pkg::PWR_POST_KEY;
  endsequence

  chk_src_key_commit: assert property (
    s_src_pre ##1 (wr_i && addr_i == clk_ctrl_pkg::SRC_ADDR) ##1 s_src_post
    |=> ref_sel_o == $past(wd_lo, 2))
    else $error("source register missed a keyed update");
  chk_src_key_guard: assert property (
    $changed(ref_sel_o) |-> $past(commit_w[0]))
    else $error("source register changed without keys");
  chk_pwr_key_commit: assert property (
    s_pwr_pre ##1 (wr_i && addr_i == clk_ctrl_pkg::PWR_ADDR)
    ##1 (s_pwr_post and !wake_rise)
    |=> power_control_o == $past(wd_byte, 2))
    else $error("power register missed a keyed update");
  chk_lock_loss_flag: assert property (
    $fell(lock_s) |=> irq_o)
    else $error("lock loss did not set the flag");
  chk_flag_write_clear: assert property (
    irq_o && sta_clr && !lock_fell |=> !irq_o [*2] or !irq_o ##1 irq_o)
    else $error("flag not cleared by write of one");
  chk_flash_div_lock: assert property (
    !lock_s [*2] |-> flash_div8_o ##1 flash_div8_o)
    else $error("flash clock not divided while unlocked");
  chk_core_wake_run: assert property (
    osc_s && power_control_o[clk_ctrl_pkg::PWR_CORE_BIT] |=> core_run_o)
    else $error("core not running once pll oscillates");
  chk_lp_osc_on: assert property (
    ##1 lp_osc_en_o)
    else $error("low power oscillator enable dropped");
  chk_status_read: assert property (
    rd_i && addr_i == clk_ctrl_pkg::STA_ADDR
    |=> rdata_o == {29'h0, $past(sta_w)})
    else $error("status read does not show lock state");
  chk_overdue_cause: assert property (
    $rose(lock_overdue_o) |-> $past(!lock_s) && $past(waiting_r))
    else $error("overdue raised without a pending relock");

endmodule // clk_ctrl

`default_nettype wire

// [sim/test_clk_ctrl.sv]
/*
  Self-checking bench for the clock source and lock controller.
  Assumes the controller package is compiled first; drives every pin.
*/
`timescale 1ns/10ps
`default_nettype none

module test_clk_ctrl;
  // ***********************************************************
  // signals and model state
  // ***********************************************************
  localparam int WAIT = 20;  // short lock window keeps the run brief
  logic        clk_i, sys_rst_i, wr_i, rd_i;
  logic [31:0] addr_i, wdata_i, rdata_o;
  logic        crystal_input_pin_i, pll_lock_i, pll_osc_i, wake_i;
  logic [1:0]  ref_sel_o;
  logic [7:0]  power_control_o;
  logic [9:0]  pll_mult_o;
  logic        pll_ref_o, flash_div8_o, core_run_o;
  logic        lp_osc_en_o, lock_overdue_o, irq_o;
  logic [2:0]  osc_cnt;
  logic        ref_q;
  int          ref_edges, errors, n_tests, seed;
  int          sel_m, pwr_m, flag_m, lock_m, xtal_m;
  int          exp_e [4] = '{8, 4, 0, 0};
  // oscillators: lp period 4 cycles, precision period 8 cycles
  wire         lp_osc   = osc_cnt[1];
  wire         prec_osc = osc_cnt[2];

  clk_ctrl #(.LOCK_WAIT_CYCLES(WAIT)) DUT
  (
    .clk_i               (clk_i),
    .sys_rst_i           (sys_rst_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .lp_osc_i            (lp_osc),
    .prec_osc_i          (prec_osc),
    .crystal_input_pin_i (crystal_input_pin_i),
    .pll_lock_i          (pll_lock_i),
    .pll_osc_i           (pll_osc_i),
    .wake_i              (wake_i),
    .ref_sel_o           (ref_sel_o),
    .power_control_o     (power_control_o),
    .pll_ref_o           (pll_ref_o),
    .pll_mult_o          (pll_mult_o),
    .flash_div8_o        (flash_div8_o),
    .core_run_o          (core_run_o),
    .lp_osc_en_o         (lp_osc_en_o),
    .lock_overdue_o      (lock_overdue_o),
    .irq_o               (irq_o)
  );

  // ***********************************************************
  // clock, oscillators, reference edge counter
  // ***********************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // edges are counted here so a window can be measured at will
  always @(posedge clk_i)
  begin
    osc_cnt <= osc_cnt + 3'h1;
    ref_q   <= pll_ref_o;
    if (pll_ref_o && !ref_q)
      ref_edges = ref_edges + 1;
  end

  // ***********************************************************
  // compare, bus and closing tasks
  // ***********************************************************
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one-cycle write; strobe stays up so writes can follow back to back
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    addr_i <= a;
    wr_i   <= 1'b0;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk_rd(rdata_o, exp);
  endtask

  // keyed update; px/qx spoil the keys, mid 1 reads, mid 2 writes between
  task automatic key_wr(input bit src, input int d, input int px,
                        input int qx, input int mid);
    if (src)
      wr(clk_ctrl_pkg::SRC_PRE_ADDR, clk_ctrl_pkg::SRC_PRE_KEY ^ px);
    else
      wr(clk_ctrl_pkg::PWR_PRE_ADDR, clk_ctrl_pkg::PWR_PRE_KEY ^ px);
    if (mid == 1)
      rd(clk_ctrl_pkg::SRC_ADDR, sel_m);
    if (mid == 2)
      wr(clk_ctrl_pkg::STA_ADDR, 32'h0);
    wr(src ? clk_ctrl_pkg::SRC_ADDR : clk_ctrl_pkg::PWR_ADDR, d);
    if (src)
      wr(clk_ctrl_pkg::SRC_POST_ADDR, clk_ctrl_pkg::SRC_POST_KEY ^ qx);
    else
      wr(clk_ctrl_pkg::PWR_POST_ADDR, clk_ctrl_pkg::PWR_POST_KEY ^ qx);
    wr_i <= 1'b0;
    @(posedge clk_i);
    if (px == 0 && qx == 0 && mid != 2)
      if (src) sel_m = d & 3; else pwr_m = d & 255;
  endtask

  function automatic int sta_m();
    return xtal_m * 4 + lock_m * 2 + flag_m;
  endfunction

  // ***********************************************************
  // watchdog and main sequence
  // ***********************************************************
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end

  initial
  begin
    seed = 47; errors = 0; n_tests = 0; osc_cnt = 3'h0; ref_edges = 0;
    sys_rst_i = 1'b1; addr_i = 32'h0; wdata_i = 32'h0;
    wr_i = 1'b0; rd_i = 1'b0; crystal_input_pin_i = 1'b0;
    pll_lock_i = 1'b0; pll_osc_i = 1'b0; wake_i = 1'b0;
    sel_m = 0; pwr_m = 32'h79; flag_m = 0; lock_m = 0; xtal_m = 0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk_pin(32'(power_control_o), clk_ctrl_pkg::PWR_RESET);
    chk_pin(32'(ref_sel_o), 32'h0);
    chk_pin(32'(pll_mult_o), 625);
    chk_pin(32'(flash_div8_o), 1);
    chk_pin(32'(lp_osc_en_o), 1);
    chk_pin(32'(irq_o), 0);
    // every reference code, with reference edges checked for each code except the crystal code
    for (int s = 0; s < 4; s++)
    begin
      key_wr(1'b1, s, 0, 0, s & 1);
      rd(clk_ctrl_pkg::SRC_ADDR, sel_m);
      chk_pin(32'(ref_sel_o), sel_m);
      repeat (8) @(posedge clk_i);
      #1 ref_edges = 0;
      repeat (128) @(posedge clk_i);
      #1;
      if (s != 2)
        chk_pin(32'((ref_edges - exp_e[s]) ** 2 <= (s == 3 ? 0 : 1)), 1);
    end
    // broken sequences must leave the source untouched
    key_wr(1'b1, 1, 32'h100, 0, 0);
    key_wr(1'b1, 1, 0, 32'h100, 0);
    key_wr(1'b1, 1, 0, 0, 2);
    chk_pin(32'(ref_sel_o), sel_m);
    rd(clk_ctrl_pkg::SRC_PRE_ADDR, 32'h0);
    rd(32'hffff0420, 32'h0);
    key_wr(1'b1, 0, 0, 0, 0);
    // power register: random value with the wake bits low
    key_wr(1'b0, $random(seed) & 32'hc7, 0, 0, 0);
    key_wr(1'b0, 32'hff, 32'h100, 0, 0);
    rd(clk_ctrl_pkg::PWR_ADDR, pwr_m);
    chk_pin(32'(power_control_o), pwr_m);
    @(posedge clk_i);
    pll_osc_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    chk_pin(32'(core_run_o), 0);
    chk_pin(32'(lp_osc_en_o), 1);
    // wake: core may run before lock, overdue only after the window
    wake_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    pwr_m = pwr_m | 32'h38;
    chk_pin(32'(power_control_o), pwr_m);
    chk_pin(32'(core_run_o), 1);
    chk_pin(32'(lock_overdue_o), 0);
    repeat (WAIT + 2) @(posedge clk_i);
    #1;
    chk_pin(32'(lock_overdue_o), 1);
    rd(clk_ctrl_pkg::HEALTH_ADDR, 32'h3);
    // lock, live crystal level, lock loss flag and its clearing
    @(posedge clk_i);
    xtal_m = $random(seed) & 1;
    crystal_input_pin_i <= xtal_m[0];
    pll_lock_i <= 1'b1;
    lock_m = 1;
    repeat (4) @(posedge clk_i);
    #1;
    chk_pin(32'(flash_div8_o), 0);
    rd(clk_ctrl_pkg::STA_ADDR, sta_m());
    pll_lock_i <= 1'b0;
    lock_m = 0;
    flag_m = 1;
    repeat (5) @(posedge clk_i);
    #1;
    chk_pin(32'(irq_o), 1);
    chk_pin(32'(flash_div8_o), 1);
    rd(clk_ctrl_pkg::STA_ADDR, sta_m());
    wr(clk_ctrl_pkg::STA_ADDR, 32'h6);
    #1;
    chk_pin(32'(irq_o), 1);
    wr(clk_ctrl_pkg::STA_ADDR, 32'h1);
    flag_m = 0;
    #1;
    chk_pin(32'(irq_o), 0);
    rd(clk_ctrl_pkg::STA_ADDR, sta_m());
    stop_test();
  end
endmodule // test_clk_ctrl

`default_nettype wire
